// ===== verilog/ddr3_cmd_pkg.sv
// shared types and constants for the ddr3 command pin block
package ddr3_cmd_pkg;

  localparam int ADDR_W = 16;
  localparam int BANK_W = 3;
  localparam int DQ_W   = 8;
  localparam int MR_NUM = 4;

  // op-code field positions inside the mode registers, then command address bit positions
  localparam int MR0_BL_LO   = 0;
  localparam int MR0_BL_HI   = 1;
  localparam logic [1:0] MR0_BL_OTF = 2'h1;
  localparam int MR1_RTT_A   = 2;
  localparam int MR1_RTT_B   = 6;
  localparam int MR1_RTT_C   = 9;
  localparam int MR1_TDQS    = 11;
  localparam int ADDR_AP     = 10;
  localparam int ADDR_BC     = 12;
  localparam int COL_HI      = 9;

  // burst beats and their length in link clock periods
  localparam int BEATS_BL8 = 8;
  localparam int BEATS_BC4 = 4;
  localparam logic [3:0] BURST_BL8_CK = 4'(BEATS_BL8 / 2);
  localparam logic [3:0] BURST_BC4_CK = 4'(BEATS_BC4 / 2);

  localparam logic [ADDR_W-1:0] MR_RESET = 16'h0000;
  localparam logic [7:0]        BANKS_IDLE = 8'h00;

  typedef enum logic [2:0] {
    CMD_NOP, CMD_MODE, CMD_REFRESH, CMD_PRECHARGE,
    CMD_ACTIVATE, CMD_WRITE, CMD_READ, CMD_ZQCAL
  } cmd_t;

  typedef enum logic [1:0] {
    PWR_ACTIVE, PWR_PRE_PD, PWR_ACT_PD, PWR_SELF_REF
  } pwr_t;

  typedef struct packed {
    logic              ck;
    logic              resetN;
    logic              cke;
    logic              csN;
    logic              rasN;
    logic              casN;
    logic              weN;
    logic              odt;
    logic [BANK_W-1:0] ba;
    logic [ADDR_W-1:0] addr;
    logic              dqs;
    logic              dm;
    logic [DQ_W-1:0]   dq;
  } pins_t;

  typedef struct packed {
    cmd_t              cmd;
    logic [BANK_W-1:0] bank;
    logic [ADDR_W-1:0] row;
    logic [COL_HI:0]   col;
    logic              autoPre;
    logic              allBanks;
    logic              burst8;
    logic [ADDR_W-1:0] opCode;
  } decoded_t;

endpackage : ddr3_cmd_pkg

// ===== verilog/pin_sync.sv
// two-flop synchroniser for a group of pins
`timescale 1ns/1ps
module pin_sync
  import ddr3_cmd_pkg::*;
#(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_b,
  // data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] q_d;

  always_comb
  begin
    meta_d = d;
    q_d    = meta_q;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      meta_q <= '0;
      q      <= '0;
    end
    else
    begin
      meta_q <= meta_d;
      q      <= q_d;
    end
  end

endmodule : pin_sync

// ===== verilog/mode_reg_file.sv
// four mode registers loaded by the load mode command
`timescale 1ns/1ps
module mode_reg_file
  import ddr3_cmd_pkg::*;
(
  // clock and reset
  input  wire logic                           clk,
  input  wire logic                           rst_b,
  input  wire logic                           clear,
  // write port
  input  wire logic                           wrEn,
  input  wire logic [1:0]                     wrSel,
  input  wire logic [ADDR_W-1:0]              wrData,
  // registered contents
  output logic      [MR_NUM-1:0][ADDR_W-1:0]  modeRegs
);

  logic [MR_NUM-1:0][ADDR_W-1:0] regs_d;

  always_comb
  begin
    regs_d = modeRegs;
    if (clear)
      regs_d = {MR_NUM{MR_RESET}};
    else if (wrEn)
      regs_d[wrSel] = wrData;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
      modeRegs <= {MR_NUM{MR_RESET}};
    else
      modeRegs <= regs_d;
  end

endmodule : mode_reg_file

// ===== verilog/ddr3_cmd_pins.sv
// ddr3 device command, address and control pin logic
`timescale 1ns/1ps
module ddr3_cmd_pins
  import ddr3_cmd_pkg::*;
(
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst_b,
  // device pins from the controller
  input  wire pins_t             pinsIn,
  // read data from the array
  input  wire logic [DQ_W-1:0]   rdData,
  // strobe and data toward the controller
  output logic                   dqsOut,
  output logic                   dqsOe,
  output logic [DQ_W-1:0]        dqOut,
  output logic                   dqOe,
  // decoded commands
  output logic                   cmdValid,
  output decoded_t               cmdOut,
  // accepted write beats
  output logic                   wrValid,
  output logic [DQ_W-1:0]        wrData,
  // status
  output pwr_t                   pwrState,
  output logic [7:0]             bankOpen,
  output logic                   termOn,
  output logic                   tdqsOn,
  output logic [MR_NUM-1:0][ADDR_W-1:0] modeRegs
);

  pins_t pins;

  pin_sync #(.W($bits(pins_t))) syncPins (
    .clk   (clk),
    .rst_b (rst_b),
    .d     (pinsIn),
    .q     (pins)
  );

  logic        ckPrev_q;
  logic        dqsPrev_q;
  logic        ckRise;
  logic        ckEdge;
  logic        dqsEdge;
  logic        devReset;
  logic        mrWrite;
  cmd_t        cmd;
  pwr_t        pwr_q, pwr_d;
  logic [7:0]  bank_q, bank_d;
  logic        cmdValid_d;
  decoded_t    cmdOut_d;
  logic [3:0]  rdCnt_q, rdCnt_d;
  logic [3:0]  wrCnt_q, wrCnt_d;
  logic        dqsOut_d, dqOe_d;
  logic [DQ_W-1:0] dqOut_d;
  logic        wrValid_d;
  logic [DQ_W-1:0] wrData_d;
  logic        termOn_d;
  logic        otfChop, rttOff, maskOff, burst8, decodeOn, allIdle;

  // reset pin clears state with no link clock edge needed
  assign devReset = !pins.resetN;
  assign ckRise   = pins.ck && !ckPrev_q;
  assign ckEdge   = pins.ck != ckPrev_q;
  assign dqsEdge  = pins.dqs != dqsPrev_q;
  assign allIdle  = bank_q == BANKS_IDLE;
  assign otfChop  = modeRegs[0][MR0_BL_HI:MR0_BL_LO] == MR0_BL_OTF;
  assign rttOff   = !(modeRegs[1][MR1_RTT_A] || modeRegs[1][MR1_RTT_B] || modeRegs[1][MR1_RTT_C]);
  assign maskOff  = modeRegs[1][MR1_TDQS];
  assign tdqsOn   = maskOff;
  // chop sampled from a12 only when enabled
  assign burst8   = !otfChop || pins.addr[ADDR_BC];
  // decoder only sees pins while fully powered
  assign decodeOn = ckRise && pwr_q == PWR_ACTIVE && pins.cke;
  assign mrWrite  = decodeOn && cmd == CMD_MODE;
  assign dqsOe    = rdCnt_q != 4'h0;

  always_comb
  begin
    cmd = CMD_NOP;
    // chip select high masks the command
    if (!pins.csN)
    begin
      case ({pins.rasN, pins.casN, pins.weN})
        3'b000:  cmd = CMD_MODE;
        3'b001:  cmd = CMD_REFRESH;
        3'b010:  cmd = CMD_PRECHARGE;
        3'b011:  cmd = CMD_ACTIVATE;
        3'b100:  cmd = CMD_WRITE;
        3'b101:  cmd = CMD_READ;
        3'b110:  cmd = CMD_ZQCAL;
        default: cmd = CMD_NOP;
      endcase
    end
  end

  // op-code into register picked by bank inputs
  mode_reg_file modeFile (
    .clk      (clk),
    .rst_b    (rst_b),
    .clear    (devReset),
    .wrEn     (mrWrite),
    .wrSel    (pins.ba[1:0]),
    .wrData   (pins.addr),
    .modeRegs (modeRegs)
  );

  // command, bank and power state
  always_comb
  begin
    pwr_d      = pwr_q;
    bank_d     = bank_q;
    cmdValid_d = 1'b0;
    cmdOut_d   = cmdOut;
    if (devReset)
    begin
      pwr_d  = PWR_ACTIVE;
      bank_d = BANKS_IDLE;
    end
    else
    begin
      case (pwr_q)
        PWR_ACTIVE:
        begin
          if (decodeOn && cmd != CMD_NOP)
          begin
            cmdValid_d        = 1'b1;
            cmdOut_d.cmd      = cmd;
            // bank inputs name the target bank
            cmdOut_d.bank     = pins.ba;
            // row on activate, column on read or write
            cmdOut_d.row      = pins.addr;
            cmdOut_d.col      = pins.addr[COL_HI:0];
            cmdOut_d.autoPre  = pins.addr[ADDR_AP] && (cmd == CMD_READ || cmd == CMD_WRITE);
            cmdOut_d.allBanks = pins.addr[ADDR_AP] && cmd == CMD_PRECHARGE;
            cmdOut_d.burst8   = burst8;
            cmdOut_d.opCode   = pins.addr;
            case (cmd)
              CMD_ACTIVATE:  bank_d[pins.ba] = 1'b1;
              CMD_PRECHARGE:
              begin
                if (pins.addr[ADDR_AP])
                  bank_d = BANKS_IDLE;
                else
                  bank_d[pins.ba] = 1'b0;
              end
              CMD_READ, CMD_WRITE:
              begin
                if (pins.addr[ADDR_AP])
                  bank_d[pins.ba] = 1'b0;
              end
              default: bank_d = bank_q;
            endcase
          end
          // cke registered low picks low-power state
          if (ckRise && !pins.cke)
          begin
            if (!pins.csN && cmd == CMD_REFRESH && allIdle)
              pwr_d = PWR_SELF_REF;
            else if (allIdle)
              pwr_d = PWR_PRE_PD;
            else
              pwr_d = PWR_ACT_PD;
          end
        end
        PWR_PRE_PD, PWR_ACT_PD:
        begin
          // power-down exit on a clock edge
          if (ckRise && pins.cke)
            pwr_d = PWR_ACTIVE;
        end
        PWR_SELF_REF:
        begin
          // self refresh exit without a clock edge
          if (pins.cke)
            pwr_d = PWR_ACTIVE;
        end
        default: pwr_d = PWR_ACTIVE;
      endcase
    end
  end

  // read strobe, termination and write capture
  always_comb
  begin
    rdCnt_d   = rdCnt_q;
    wrCnt_d   = wrCnt_q;
    dqsOut_d  = 1'b0;
    dqOe_d    = 1'b0;
    dqOut_d   = dqOut;
    wrValid_d = 1'b0;
    wrData_d  = wrData;
    termOn_d  = termOn;
    if (devReset)
    begin
      rdCnt_d  = 4'h0;
      wrCnt_d  = 4'h0;
      termOn_d = 1'b0;
    end
    else
    begin
      if (decodeOn && cmd == CMD_READ)
        rdCnt_d = burst8 ? BURST_BL8_CK : BURST_BC4_CK;
      else if (ckRise && rdCnt_q != 4'h0)
        rdCnt_d = rdCnt_q - 4'h1;
      if (decodeOn && cmd == CMD_WRITE)
        wrCnt_d = burst8 ? 4'(BEATS_BL8) : 4'(BEATS_BC4);
      // strobe follows link clock, data edge aligned
      // burst window opens on the command rise and closes on the last counted rise
      if (rdCnt_d != 4'h0)
      begin
        dqsOut_d = pins.ck;
        dqOe_d   = 1'b1;
        if (ckEdge)
          dqOut_d = rdData;
      end
      // write beat taken on each incoming strobe edge
      if (dqsEdge && wrCnt_q != 4'h0 && !(decodeOn && cmd == CMD_WRITE))
      begin
        wrCnt_d = wrCnt_q - 4'h1;
        // masked beats dropped unless mask pin is repurposed
        if (!(pins.dm && !maskOff))
        begin
          wrValid_d = 1'b1;
          wrData_d  = pins.dq;
        end
      end
      // odt registered on clock edge, ignored when disabled
      if (rttOff)
        termOn_d = 1'b0;
      else if (ckRise && pwr_q != PWR_SELF_REF)
        termOn_d = pins.odt;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      ckPrev_q  <= 1'b0;
      dqsPrev_q <= 1'b0;
      pwr_q     <= PWR_ACTIVE;
      bank_q    <= BANKS_IDLE;
      cmdValid  <= 1'b0;
      cmdOut    <= '0;
      rdCnt_q   <= 4'h0;
      wrCnt_q   <= 4'h0;
      dqsOut    <= 1'b0;
      dqOe      <= 1'b0;
      dqOut     <= '0;
      wrValid   <= 1'b0;
      wrData    <= '0;
      termOn    <= 1'b0;
    end
    else
    begin
      ckPrev_q  <= pins.ck;
      dqsPrev_q <= pins.dqs;
      pwr_q     <= pwr_d;
      bank_q    <= bank_d;
      cmdValid  <= cmdValid_d;
      cmdOut    <= cmdOut_d;
      rdCnt_q   <= rdCnt_d;
      wrCnt_q   <= wrCnt_d;
      dqsOut    <= dqsOut_d;
      dqOe      <= dqOe_d;
      dqOut     <= dqOut_d;
      wrValid   <= wrValid_d;
      wrData    <= wrData_d;
      termOn    <= termOn_d;
    end
  end

  assign pwrState = pwr_q;
  assign bankOpen = bank_q;

  cs_mask_a: assert property (@(posedge clk) disable iff (!rst_b)
    ckRise && pins.csN |=> !cmdValid) else $error("command accepted with chip select high");

  pre_all_a: assert property (@(posedge clk) disable iff (!rst_b)
    decodeOn && cmd == CMD_PRECHARGE && pins.addr[ADDR_AP] && !devReset |=> bankOpen == BANKS_IDLE)
    else $error("precharge all left a bank open");

  act_bank_a: assert property (@(posedge clk) disable iff (!rst_b)
    decodeOn && cmd == CMD_ACTIVATE && !devReset |=> bankOpen[cmdOut.bank] && cmdOut.cmd == CMD_ACTIVATE)
    else $error("activate did not open the addressed bank");

  sr_exit_a: assert property (@(posedge clk) disable iff (!rst_b)
    pwr_q == PWR_SELF_REF && pins.cke |=> pwrState == PWR_ACTIVE)
    else $error("self refresh exit not taken without clock");

  pd_quiet_a: assert property (@(posedge clk) disable iff (!rst_b)
    pwr_q != PWR_ACTIVE |=> !cmdValid) else $error("command decoded in low power state");

  odt_off_a: assert property (@(posedge clk) disable iff (!rst_b)
    rttOff |=> !termOn) else $error("termination on while disabled");

  mask_drop_a: assert property (@(posedge clk) disable iff (!rst_b)
    dqsEdge && wrCnt_q != 4'h0 && pins.dm && !maskOff |=> !wrValid)
    else $error("masked write beat accepted");

  bc4_len_a: assert property (@(posedge clk) disable iff (!rst_b)
    decodeOn && cmd == CMD_READ && otfChop && !pins.addr[ADDR_BC] && !devReset |=> rdCnt_q == BURST_BC4_CK)
    else $error("chopped read has wrong length");

  apd_entry_a: assert property (@(posedge clk) disable iff (!rst_b)
    pwr_q == PWR_ACTIVE && ckRise && !pins.cke && !allIdle && !devReset |=> pwrState == PWR_ACT_PD)
    else $error("active power-down not entered");

endmodule : ddr3_cmd_pins

// ===== dv/ddr3_ctl_model.sv
// controller-side model driving the device pins
`timescale 1ns/1ps
module ddr3_ctl_model
  import ddr3_cmd_pkg::*;
(
  // clock
  input  wire logic  clk,
  // pins toward the device
  output pins_t      pins
);
  initial
  begin
    pins = '0;
    pins.resetN = 1'b1;
    pins.cke = 1'b1;
    pins.csN = 1'b1;
    {pins.rasN, pins.casN, pins.weN} = 3'b111;
  end

  // one link clock period carrying a command
  task automatic cmd(input logic cs, input logic [2:0] code, input logic [2:0] ba, input logic [15:0] a);
    @(negedge clk);
    pins.csN = cs;
    {pins.rasN, pins.casN, pins.weN} = code;
    pins.ba = ba;
    pins.addr = a;
    repeat (20) @(negedge clk);
    pins.ck = 1'b1;
    repeat (20) @(negedge clk);
    pins.ck = 1'b0;
    pins.csN = 1'b1;
    pins.addr = ~a;
    pins.ba = ~ba;
  endtask : cmd

  // static levels, then time to pass the sync flops
  task automatic lvl(input logic cke, input logic odt, input logic rstN);
    @(negedge clk);
    pins.cke = cke;
    pins.odt = odt;
    pins.resetN = rstN;
    repeat (4) @(negedge clk);
  endtask : lvl

  // eight write beats, strobe toggled mid-beat
  task automatic beats(input logic [7:0] mask);
    for (int i = 0; i < BEATS_BL8; i++)
    begin
      @(negedge clk);
      pins.dq = 8'h10 + 8'(i);
      pins.dm = mask[i];
      repeat (5) @(negedge clk);
      pins.dqs = ~pins.dqs;
      repeat (5) @(negedge clk);
    end
    pins.dq = ~pins.dq;
    pins.dm = ~pins.dm;
  endtask : beats
endmodule : ddr3_ctl_model

// ===== dv/ddr3_cmd_pins_test.sv
// self-checking bench for the ddr3 command pin block
`timescale 1ns/1ps
module ddr3_cmd_pins_test
  import ddr3_cmd_pkg::*;
;
  logic                           clk;
  logic                           rst_b;
  pins_t                          pins;
  logic [DQ_W-1:0]                rdData = '0;
  logic                           dqsOut;
  logic                           dqsOe;
  logic [DQ_W-1:0]                dqOut;
  logic                           dqOe;
  logic                           cmdValid;
  decoded_t                       cmdOut;
  logic                           wrValid;
  logic [DQ_W-1:0]                wrData;
  pwr_t                           pwrState;
  logic [7:0]                     bankOpen;
  logic                           termOn;
  logic                           tdqsOn;
  logic [MR_NUM-1:0][ADDR_W-1:0]  modeRegs;
  int                             mismatches;
  int                             numChecks;
  int                             nCmd;
  int                             nWr;
  int                             n0;
  logic                           sawRd = 1'b0;
  int                             nDqs;
  logic                           dqsLast = 1'b0;

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  ddr3_ctl_model i_ctl (.clk(clk), .pins(pins));

  ddr3_cmd_pins i_dut (
    .clk(clk), .rst_b(rst_b), .pinsIn(pins), .rdData(rdData), .dqsOut(dqsOut), .dqsOe(dqsOe),
    .dqOut(dqOut), .dqOe(dqOe), .cmdValid(cmdValid), .cmdOut(cmdOut), .wrValid(wrValid),
    .wrData(wrData), .pwrState(pwrState), .bankOpen(bankOpen), .termOn(termOn), .tdqsOn(tdqsOn),
    .modeRegs(modeRegs)
  );

  // new array word on every link clock rise
  always @(posedge pins.ck)
  begin
    rdData <= rdData + 8'h01;
  end

  always @(negedge clk)
  begin
    if (cmdValid === 1'b1)
      nCmd++;
    if (wrValid === 1'b1)
      nWr++;
    if (dqOe === 1'b1)
      sawRd = 1'b1;
    if (dqsOut === 1'b1 && dqsLast === 1'b0)
      nDqs++;
    dqsLast = dqsOut;
    if (dqsOe !== dqOe)
    begin
      mismatches++;
      $display("MISMATCH t=%0t strobe and data enables differ", $time);
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    numChecks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic end_sim();
    $display("checks %0d mismatches %0d", numChecks, mismatches);
    if (mismatches == 0 && numChecks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_sim

  initial
  begin
    repeat (20000) @(posedge clk);
    mismatches++;
    end_sim();
  end

  initial
  begin
    rst_b = 1'b0;
    repeat (12) @(posedge clk);
    @(negedge clk);
    rst_b = 1'b1;
    repeat (3) @(negedge clk);
    chk(pwrState, PWR_ACTIVE);
    for (int i = 0; i < MR_NUM; i++)
    begin
      i_ctl.cmd(1'b0, 3'b000, 3'(i), 16'h0001 << (2 * i));
      chk(modeRegs[i], 16'h0001 << (2 * i));
    end
    i_ctl.cmd(1'b0, 3'b011, 3'h5, 16'ha5c3);
    chk(cmdOut.row, 16'ha5c3);
    chk(bankOpen, 8'h20);
    n0 = nCmd;
    i_ctl.cmd(1'b1, 3'b011, 3'h6, 16'h1111);
    chk(nCmd, n0);
    chk(bankOpen, 8'h20);
    i_ctl.cmd(1'b0, 3'b100, 3'h5, 16'h12ab);
    chk(cmdOut.cmd, CMD_WRITE);
    chk({cmdOut.col, cmdOut.autoPre, cmdOut.burst8}, {10'h2ab, 2'b01});
    i_ctl.beats(8'b0010_0100);
    chk(nWr, 6);
    chk(wrData, 8'h17);
    i_ctl.cmd(1'b0, 3'b101, 3'h5, 16'h0455);
    chk(cmdOut.cmd, CMD_READ);
    chk({cmdOut.col, cmdOut.autoPre, cmdOut.burst8}, {10'h055, 2'b10});
    chk(bankOpen, 8'h00);
    i_ctl.cmd(1'b1, 3'b111, 3'h0, 16'h0000);
    i_ctl.cmd(1'b1, 3'b111, 3'h0, 16'h0000);
    chk(sawRd, 1'b1);
    chk(nDqs, BURST_BC4_CK);
    chk(dqOut, 8'(rdData - 8'h01));
    i_ctl.cmd(1'b0, 3'b011, 3'h1, 16'h0001);
    i_ctl.cmd(1'b0, 3'b011, 3'h2, 16'h0002);
    i_ctl.cmd(1'b0, 3'b010, 3'h1, 16'h0000);
    chk({bankOpen, cmdOut.allBanks}, {8'h04, 1'b0});
    i_ctl.cmd(1'b0, 3'b010, 3'h0, 16'h0400);
    chk({bankOpen, cmdOut.allBanks}, {8'h00, 1'b1});
    i_ctl.cmd(1'b0, 3'b001, 3'h0, 16'h0000);
    chk(cmdOut.cmd, CMD_REFRESH);
    i_ctl.cmd(1'b0, 3'b110, 3'h0, 16'h0000);
    chk(cmdOut.cmd, CMD_ZQCAL);
    n0 = nCmd;
    i_ctl.cmd(1'b0, 3'b111, 3'h0, 16'h0000);
    chk(nCmd, n0);
    i_ctl.cmd(1'b0, 3'b011, 3'h4, 16'h0004);
    i_ctl.lvl(1'b0, 1'b0, 1'b1);
    i_ctl.cmd(1'b1, 3'b111, 3'h0, 16'h0000);
    chk(pwrState, PWR_ACT_PD);
    n0 = nCmd;
    i_ctl.cmd(1'b0, 3'b011, 3'h6, 16'h0006);
    chk(nCmd, n0);
    i_ctl.lvl(1'b1, 1'b0, 1'b1);
    i_ctl.cmd(1'b1, 3'b111, 3'h0, 16'h0000);
    chk(pwrState, PWR_ACTIVE);
    i_ctl.cmd(1'b0, 3'b010, 3'h0, 16'h0400);
    i_ctl.lvl(1'b0, 1'b0, 1'b1);
    i_ctl.cmd(1'b1, 3'b111, 3'h0, 16'h0000);
    chk(pwrState, PWR_PRE_PD);
    i_ctl.lvl(1'b1, 1'b0, 1'b1);
    i_ctl.cmd(1'b1, 3'b111, 3'h0, 16'h0000);
    i_ctl.lvl(1'b0, 1'b0, 1'b1);
    i_ctl.cmd(1'b0, 3'b001, 3'h0, 16'h0000);
    i_ctl.lvl(1'b0, 1'b1, 1'b1);
    i_ctl.cmd(1'b1, 3'b111, 3'h0, 16'h0000);
    chk({pwrState, termOn}, {PWR_SELF_REF, 1'b0});
    i_ctl.lvl(1'b1, 1'b1, 1'b1);
    chk(pwrState, PWR_ACTIVE);
    i_ctl.cmd(1'b1, 3'b111, 3'h0, 16'h0000);
    chk(termOn, 1'b1);
    i_ctl.cmd(1'b0, 3'b000, 3'h1, 16'h0000);
    i_ctl.cmd(1'b1, 3'b111, 3'h0, 16'h0000);
    chk(termOn, 1'b0);
    i_ctl.cmd(1'b0, 3'b000, 3'h1, 16'h0800);
    chk({tdqsOn, cmdOut.opCode}, {1'b1, 16'h0800});
    i_ctl.cmd(1'b0, 3'b011, 3'h3, 16'h0003);
    i_ctl.cmd(1'b0, 3'b100, 3'h3, 16'h0000);
    chk({cmdOut.bank, cmdOut.burst8}, {3'h3, 1'b0});
    i_ctl.beats(8'hff);
    chk(nWr, 10);
    chk(wrData, 8'h13);
    i_ctl.cmd(1'b0, 3'b011, 3'h0, 16'h0007);
    i_ctl.lvl(1'b1, 1'b0, 1'b0);
    chk({modeRegs[0], bankOpen}, 24'h0);
    i_ctl.lvl(1'b1, 1'b0, 1'b1);
    end_sim();
  end
endmodule : ddr3_cmd_pins_test
